// ### verilog/mmc_pkg.sv
// constants shared by the memory map and mode control block
`default_nettype none
package mmc_pkg;
  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [5:0] IDX_MODE   = 6'h0b;
  localparam logic [5:0] IDX_DIRECT = 6'h11;
  localparam logic [5:0] IDX_PROGRAM_PAGE_INDEX  = 6'h15;
  localparam logic [5:0] IDX_STATUS = 6'h20;
  // ==========================================================
  // field positions
  localparam int MODE_SEL_BIT   = 7;
  localparam int STAT_LOCK_BIT  = 0;
  localparam int STAT_DWR_BIT   = 1;
  localparam int STAT_SEC_BIT   = 2;
  localparam int STAT_SPEC_BIT  = 3;
  // ==========================================================
  // reset values and encodings
  localparam logic [3:0] PROGRAM_PAGE_INDEX_RST     = 4'he;
  localparam logic [7:0] DIRECT_RST    = 8'h00;
  localparam logic       MODE_NORMAL   = 1'b1;
  localparam logic       MODE_SPECIAL  = 1'b0;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;
  // ==========================================================
  // local map layout
  localparam logic [1:0] WINDOW_SLOT   = 2'h2;
  localparam logic [1:0] FIXED_PAGE_HI = 2'h3;
  localparam logic [3:0] PFLASH_FIRST  = 4'hc;
endpackage
`default_nettype wire

// ### verilog/mmc_page_map.sv
// local to global address mapper, one per bus master
`default_nettype none
module mmc_page_map
(
  input  wire logic [15:0] local_addr,
  input  wire logic        direct_mode,
  input  wire logic [7:0]  direct_base,
  input  wire logic [3:0]  page_index,
  input  wire logic [3:0]  first_page,
  output logic      [17:0] global_addr,
  output logic             is_pflash,
  output logic             unimpl
);
  logic [15:0] eff;
  logic [3:0]  page;

  // direct accesses take their upper byte from the base register
  assign eff = direct_mode ? {direct_base, local_addr[7:0]} : local_addr; // [RULE_13]

  // window slot pages by index, the other slots are fixed pages
  assign page = (eff[15:14] == mmc_pkg::WINDOW_SLOT) ? page_index   // [RULE_14]
              : {mmc_pkg::FIXED_PAGE_HI, eff[15:14]};

  // 4 page bits over 14 offset bits span the 256 KByte space
  assign global_addr = {page, eff[13:0]}; // [RULE_08]
  // low fixed slot holds registers, rams and data flash, not program flash
  assign is_pflash = (eff[15:14] != 2'h0);
  // pages below the first implemented flash page hit nothing
  assign unimpl = is_pflash && (page < first_page);
endmodule
`default_nettype wire

// ### verilog/mmc_top.sv
// memory map, paging, arbitration and mode control with an axi4-lite register port
// Notes on behaviour
// [RULE_01] mode pin level is loaded into the mode selector when reset releases.
// [RULE_02] during reset mode follows the pin, afterwards the selector bit 7.
// [RULE_03] mode register at index 0x0b, selector in bit 7, rest zero, always readable.
// [RULE_04] disallowed mode write keeps selector; outside special mode it locks further writes.
// [RULE_05] while secured every write to the mode register is ignored.
// [RULE_06] special mode enters background debug after every reset.
// [RULE_07] processor access to unimplemented space requests a system reset.
// [RULE_08] paging reaches a 256 KByte global space from the local maps.
// [RULE_09] concurrent processor and debug requests are granted one at a time.
// [RULE_10] each master has its own local to global map.
// [RULE_11] secured device denies debug path access to program flash.
// [RULE_12] special to normal is allowed, normal to special is disallowed.
// [RULE_13] direct base register supplies local address bits 15 to 8.
// [RULE_14] page index selects the 16KB block shown at 0x8000 to 0xbfff.
// [RULE_15] page index register resets to 0x0e.
`default_nettype none
module mmc_top
#(
  parameter int          ADDR_W       = 8,
  parameter logic [3:0]  FIRST_PAGE   = mmc_pkg::PFLASH_FIRST
)
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite register port
  input  wire logic [ADDR_W-1:0] s_awaddr,
  input  wire logic              s_awvalid,
  output logic                   s_awready,
  input  wire logic [31:0]       s_wdata,
  input  wire logic [3:0]        s_wstrb,
  input  wire logic              s_wvalid,
  output logic                   s_wready,
  output logic [1:0]             s_bresp,
  output logic                   s_bvalid,
  input  wire logic              s_bready,
  input  wire logic [ADDR_W-1:0] s_araddr,
  input  wire logic              s_arvalid,
  output logic                   s_arready,
  output logic [31:0]            s_rdata,
  output logic [1:0]             s_rresp,
  output logic                   s_rvalid,
  input  wire logic              s_rready,
  // mode pin and security state
  input  wire logic              mode_select_pin_bit,
  input  wire logic              secure_in,
  // processor master
  input  wire logic              cpu_req,
  input  wire logic [15:0]       cpu_addr,
  input  wire logic              cpu_direct,
  input  wire logic              cpu_we,
  input  wire logic [15:0]       cpu_wdata,
  output logic                   cpu_gnt,
  // debug master, with its own page register
  input  wire logic              dbg_req,
  input  wire logic [15:0]       dbg_addr,
  input  wire logic              dbg_we,
  input  wire logic [15:0]       dbg_wdata,
  input  wire logic              dbg_page_en,
  input  wire logic [3:0]        dbg_page,
  output logic                   dbg_gnt,
  output logic                   dbg_denied,
  // shared resource port
  output logic                   mem_req,
  output logic [17:0]            mem_addr,
  output logic                   mem_we,
  output logic [15:0]            mem_wdata,
  output logic                   mem_from_dbg,
  // mode and system outputs
  output logic                   normal_single_chip,
  output logic                   background_debug,
  output logic                   sys_reset_req
);
  // ==========================================================
  // elaboration checks
  if (ADDR_W < 8 || ADDR_W > 32)
  begin : g_chk_aw
    $error("address width must be 8 to 32 bits");
  end

  // ==========================================================
  // mode pin synchroniser
  logic pin_s1_q;
  logic pin_s2_q;

  // no reset here: the pin must keep being tracked while reset is low
  always_ff @(posedge aclk)
  begin
    pin_s1_q <= mode_select_pin_bit;
    pin_s2_q <= pin_s1_q;
  end

  // ==========================================================
  // register state
  logic       mode_q;
  logic       mode_lock_q;
  logic [7:0] direct_q;
  logic       direct_wr_q;
  logic [3:0] program_page_index_q;
  logic       rst_seen_q;
  logic       bdm_q;

  // write path signals
  logic              aw_held_q;
  logic              w_held_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              do_write;
  logic [5:0]        w_idx;
  logic              w_mapped;
  logic              w_lane0;

  assign do_write = aw_held_q && w_held_q && !s_bvalid;
  assign w_idx    = awaddr_q[7:2];
  assign w_lane0  = wstrb_q[0];

  // decode of the write index, upper address bits must be clear
  always_comb
  begin
    w_mapped = 1'b0;
    if ((awaddr_q >> 8) != '0 || awaddr_q[1:0] != 2'h0)
      w_mapped = 1'b0;
    else if (w_idx == mmc_pkg::IDX_MODE)
      w_mapped = 1'b1;
    else if (w_idx == mmc_pkg::IDX_DIRECT)
      w_mapped = 1'b1;
    else if (w_idx == mmc_pkg::IDX_PROGRAM_PAGE_INDEX)
      w_mapped = 1'b1;
    else if (w_idx == mmc_pkg::IDX_STATUS)
      w_mapped = 1'b1;
  end

  // ==========================================================
  // mode selector
  logic mode_wr;
  logic mode_new;

  assign mode_wr  = do_write && w_mapped && w_lane0 && (w_idx == mmc_pkg::IDX_MODE);
  assign mode_new = wdata_q[mmc_pkg::MODE_SEL_BIT];

  // reset is synchronous, so the selector may track the pin while held
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mode_q <= pin_s2_q; // [RULE_01] [RULE_02]
    else if (mode_wr && !secure_in && !mode_lock_q) // [RULE_05]
    begin
      // only special to normal moves, a normal to special request is dropped
      if (mode_q == mmc_pkg::MODE_SPECIAL) // [RULE_12]
        mode_q <= mode_new;
    end
  end

  // a refused request outside special mode freezes the selector until the next reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mode_lock_q <= 1'b0;
    else if (mode_wr && !secure_in && mode_q == mmc_pkg::MODE_NORMAL
             && mode_new == mmc_pkg::MODE_SPECIAL)
      mode_lock_q <= 1'b1; // [RULE_04]
  end

  // ==========================================================
  // direct base and page index
  // direct base is free in special mode, writable once in normal mode
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      direct_q    <= mmc_pkg::DIRECT_RST;
      direct_wr_q <= 1'b0;
    end
    else if (do_write && w_mapped && w_lane0 && w_idx == mmc_pkg::IDX_DIRECT)
    begin
      if (mode_q == mmc_pkg::MODE_SPECIAL || !direct_wr_q)
        direct_q <= wdata_q[7:0];
      direct_wr_q <= 1'b1;
    end
  end

  // page index, low four bits only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      program_page_index_q <= mmc_pkg::PROGRAM_PAGE_INDEX_RST; // [RULE_15]
    else if (do_write && w_mapped && w_lane0 && w_idx == mmc_pkg::IDX_PROGRAM_PAGE_INDEX)
      program_page_index_q <= wdata_q[3:0];
  end

  // ==========================================================
  // debug entry after reset
  // one cycle after release the selector holds the captured pin level
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rst_seen_q <= 1'b0;
      bdm_q      <= 1'b0;
    end
    else if (!rst_seen_q)
    begin
      rst_seen_q <= 1'b1;
      bdm_q      <= (mode_q == mmc_pkg::MODE_SPECIAL); // [RULE_06]
    end
  end

  assign normal_single_chip = mode_q; // [RULE_02]
  assign background_debug   = bdm_q;

  // ==========================================================
  // axi4-lite write channel
  // address and data are taken independently, one write at a time
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end
    else
    begin
      if (s_awvalid && s_awready)
      begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_awaddr;
      end
      else if (do_write)
        aw_held_q <= 1'b0;
      if (s_wvalid && s_wready)
      begin
        w_held_q <= 1'b1;
        wdata_q  <= s_wdata;
        wstrb_q  <= s_wstrb;
      end
      else if (do_write)
        w_held_q <= 1'b0;
    end
  end

  assign s_awready = !aw_held_q && !s_bvalid && aresetn;
  assign s_wready  = !w_held_q && !s_bvalid && aresetn;

  // write response, unmapped slots answer slverr
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_bvalid <= 1'b0;
      s_bresp  <= mmc_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      s_bvalid <= 1'b1;
      s_bresp  <= w_mapped ? mmc_pkg::RESP_OKAY : mmc_pkg::RESP_SLVERR;
    end
    else if (s_bready)
      s_bvalid <= 1'b0;
  end

  // ==========================================================
  // axi4-lite read channel
  logic [5:0]  r_idx;
  logic [31:0] r_word;
  logic        r_mapped;

  assign r_idx     = s_araddr[7:2];
  assign s_arready = !s_rvalid && aresetn;

  // read decode, reserved bits read as zero
  always_comb
  begin
    r_word   = 32'h0000_0000;
    r_mapped = 1'b1;
    if ((s_araddr >> 8) != '0 || s_araddr[1:0] != 2'h0)
      r_mapped = 1'b0;
    else if (r_idx == mmc_pkg::IDX_MODE)
      r_word[mmc_pkg::MODE_SEL_BIT] = mode_q; // [RULE_03]
    else if (r_idx == mmc_pkg::IDX_DIRECT)
      r_word[7:0] = direct_q;
    else if (r_idx == mmc_pkg::IDX_PROGRAM_PAGE_INDEX)
      r_word[3:0] = program_page_index_q;
    else if (r_idx == mmc_pkg::IDX_STATUS)
    begin
      r_word[mmc_pkg::STAT_LOCK_BIT] = mode_lock_q;
      r_word[mmc_pkg::STAT_DWR_BIT]  = direct_wr_q;
      r_word[mmc_pkg::STAT_SEC_BIT]  = secure_in;
      r_word[mmc_pkg::STAT_SPEC_BIT] = (mode_q == mmc_pkg::MODE_SPECIAL);
    end
    else
      r_mapped = 1'b0;
  end

  // read data is sampled at the address handshake
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h0000_0000;
      s_rresp  <= mmc_pkg::RESP_OKAY;
    end
    else if (s_arvalid && s_arready)
    begin
      s_rvalid <= 1'b1;
      s_rdata  <= r_word;
      s_rresp  <= r_mapped ? mmc_pkg::RESP_OKAY : mmc_pkg::RESP_SLVERR;
    end
    else if (s_rready)
      s_rvalid <= 1'b0;
  end

  // ==========================================================
  // per-master address maps
  logic [17:0] cpu_gaddr;
  logic        cpu_pfl;
  logic        cpu_unimpl;
  logic [17:0] dbg_gaddr;
  logic        dbg_pfl;
  logic        dbg_unimpl;

  // processor map: direct base and page index register
  mmc_page_map u_cpu_map // [RULE_10]
  (
    .local_addr  (cpu_addr),
    .direct_mode (cpu_direct),
    .direct_base (direct_q),
    .page_index  (program_page_index_q),
    .first_page  (FIRST_PAGE),
    .global_addr (cpu_gaddr),
    .is_pflash   (cpu_pfl),
    .unimpl      (cpu_unimpl)
  );

  // debug map: its own page register when enabled
  mmc_page_map u_dbg_map // [RULE_10]
  (
    .local_addr  (dbg_addr),
    .direct_mode (1'b0),
    .direct_base (direct_q),
    .page_index  (dbg_page_en ? dbg_page : program_page_index_q),
    .first_page  (FIRST_PAGE),
    .global_addr (dbg_gaddr),
    .is_pflash   (dbg_pfl),
    .unimpl      (dbg_unimpl)
  );

  // ==========================================================
  // arbitration
  logic last_dbg_q;
  logic pick_dbg;
  logic pick_cpu;
  logic gnt_busy;

  // grants are one-cycle pulses, requests stay high until granted
  assign gnt_busy = cpu_gnt || dbg_gnt;
  // alternate priority so neither master starves the other
  assign pick_dbg = !gnt_busy && dbg_req && (!cpu_req || !last_dbg_q); // [RULE_09]
  assign pick_cpu = !gnt_busy && cpu_req && !pick_dbg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      last_dbg_q   <= 1'b0;
      cpu_gnt      <= 1'b0;
      dbg_gnt      <= 1'b0;
      dbg_denied   <= 1'b0;
      mem_req      <= 1'b0;
      mem_addr     <= 18'h0_0000;
      mem_we       <= 1'b0;
      mem_wdata    <= 16'h0000;
      mem_from_dbg <= 1'b0;
    end
    else
    begin
      cpu_gnt    <= pick_cpu;
      dbg_gnt    <= pick_dbg;
      dbg_denied <= pick_dbg && secure_in && dbg_pfl; // [RULE_11]
      mem_req    <= (pick_cpu && !cpu_unimpl)
                  || (pick_dbg && !(secure_in && dbg_pfl) && !dbg_unimpl); // [RULE_09]
      if (pick_dbg || pick_cpu)
      begin
        last_dbg_q   <= pick_dbg;
        mem_addr     <= pick_dbg ? dbg_gaddr : cpu_gaddr;
        mem_we       <= pick_dbg ? dbg_we : cpu_we;
        mem_wdata    <= pick_dbg ? dbg_wdata : cpu_wdata;
        mem_from_dbg <= pick_dbg;
      end
    end
  end

  // ==========================================================
  // unimplemented access reset
  // both modes are single-chip, so any stray processor access resets
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sys_reset_req <= 1'b0;
    else
      sys_reset_req <= pick_cpu && cpu_unimpl; // [RULE_07]
  end
endmodule
`default_nettype wire

// ### sim/mmc_checker.sv
// port assertions for the memory map and mode control block
`default_nettype none
module mmc_checker
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        secure_in,
  input wire logic [15:0] cpu_addr,
  input wire logic        cpu_direct,
  input wire logic        cpu_gnt,
  input wire logic        dbg_gnt,
  input wire logic        dbg_denied,
  input wire logic        mem_req,
  input wire logic [17:0] mem_addr,
  input wire logic        mem_from_dbg,
  input wire logic        normal_single_chip,
  input wire logic        background_debug,
  input wire logic        sys_reset_req
);
  // ==========================================
  // assertions
  // one domain, so clock and reset are stated once
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_grant_spacing: assert property ((cpu_gnt || dbg_gnt) |=> !(cpu_gnt || dbg_gnt))
    else $error("grants too close");
  a_grant_single: assert property (!(cpu_gnt && dbg_gnt))
    else $error("both masters granted");
  a_mem_owner: assert property (mem_req |-> (cpu_gnt ^ dbg_gnt) && (mem_from_dbg == dbg_gnt))
    else $error("resource access without its grant");
  a_debug_entry: assert property ($rose(aresetn) |=> background_debug == !normal_single_chip)
    else $error("debug entry does not match mode");
  a_debug_steady: assert property ($past(aresetn, 2) && $past(aresetn) |-> $stable(background_debug))
    else $error("debug state moved between resets");
  a_no_special: assert property (normal_single_chip |=> normal_single_chip)
    else $error("left normal mode");
  a_secure_hold: assert property ($past(aresetn) && $past(secure_in) |-> $stable(normal_single_chip))
    else $error("mode changed while secured");
  a_unimpl_reset: assert property (sys_reset_req |-> cpu_gnt && !mem_req)
    else $error("reset request outside a processor grant");
  a_flash_denied: assert property (dbg_denied |-> dbg_gnt && !mem_req && $past(secure_in))
    else $error("debug denial without security");
  a_fixed_low: assert property (mem_req && !mem_from_dbg && !cpu_direct && cpu_addr[15:14] == 2'h0
    |-> mem_addr == {4'hc, cpu_addr[13:0]})
    else $error("low fixed page wrong");
  a_fixed_high: assert property (mem_req && !mem_from_dbg && !cpu_direct && cpu_addr[15:14] == 2'h3
    |-> mem_addr == {4'hf, cpu_addr[13:0]})
    else $error("high fixed page wrong");
  // main scenarios reached
  c_unimpl: cover property (sys_reset_req);
  c_denied: cover property (dbg_denied);
  c_arbiter: cover property ((cpu_gnt ##2 dbg_gnt) or (dbg_gnt ##2 cpu_gnt));
endmodule
`default_nettype wire

// ### sim/mmc_master_model.sv
// processor and debug bus master model
`default_nettype none
module mmc_master_model
(
  input  wire logic        aclk,
  input  wire logic        cpu_gnt,
  input  wire logic        dbg_gnt,
  input  wire logic        dbg_denied,
  input  wire logic        mem_req,
  input  wire logic [17:0] mem_addr,
  input  wire logic        sys_reset_req,
  output var  logic        cpu_req,
  output var  logic [15:0] cpu_addr,
  output var  logic        cpu_direct,
  output var  logic        dbg_req,
  output var  logic [15:0] dbg_addr,
  output var  logic        dbg_page_en,
  output var  logic [3:0]  dbg_page
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [17:0] seen_addr;
  logic        seen_mem, seen_rst, seen_den;
  time         cpu_t, dbg_t;
  // idle masters at time zero
  initial
  begin
    {cpu_req, cpu_direct, dbg_req, dbg_page_en} = 4'h0;
    {cpu_addr, dbg_addr, dbg_page} = 36'h0;
  end
  // request held until granted; released address lines show a changed value
  task automatic cpu_go(input logic [15:0] a, input logic d);
    cpu_req <= 1'b1;
    cpu_addr <= a;
    cpu_direct <= d;
    do @(posedge aclk); while (!cpu_gnt);
    {seen_addr, seen_mem, seen_rst} = {mem_addr, mem_req, sys_reset_req};
    cpu_t = $time;
    cpu_req <= 1'b0;
    cpu_addr <= ~a;
    // let the release be sampled before a following call raises the request again
    @(posedge aclk);
  endtask
  task automatic dbg_go(input logic [15:0] a, input logic en, input logic [3:0] p);
    dbg_req <= 1'b1;
    dbg_addr <= a;
    dbg_page_en <= en;
    dbg_page <= p;
    do @(posedge aclk); while (!dbg_gnt);
    {seen_addr, seen_mem, seen_den} = {mem_addr, mem_req, dbg_denied};
    dbg_t = $time;
    dbg_req <= 1'b0;
    dbg_addr <= ~a;
    // let the release be sampled before a following call raises the request again
    @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// ### sim/mmc_top_tb_top.sv
// self-checking bench for the memory map and mode control block
`default_nettype none
module mmc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] A_MODE = {mmc_pkg::IDX_MODE, 2'b00};
  localparam logic [7:0] A_DIR  = {mmc_pkg::IDX_DIRECT, 2'b00};
  localparam logic [7:0] A_PAGE = {mmc_pkg::IDX_PROGRAM_PAGE_INDEX, 2'b00};
  localparam logic [7:0] A_STAT = {mmc_pkg::IDX_STATUS, 2'b00};
  logic        aclk = 1'b0, aresetn = 1'b0, mode_select_pin_bit = 1'b1, secure_in = 1'b0;
  logic        s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic [7:0]  s_awaddr = 8'h00, s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0;
  logic [3:0]  s_wstrb = 4'hf;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0]  s_bresp, s_rresp, rsp_q;
  logic [31:0] s_rdata, rd_q;
  logic        cpu_req, cpu_direct, cpu_gnt, dbg_req, dbg_page_en, dbg_gnt, dbg_denied;
  logic [15:0] cpu_addr, dbg_addr, mem_wdata;
  logic [3:0]  dbg_page;
  logic        mem_req, mem_we, mem_from_dbg, normal_single_chip, background_debug, sys_reset_req;
  logic [17:0] mem_addr;
  int          num_errors = 0, total_checks = 0;
  // write paths are not modelled, so the write data inputs stay tied
  mmc_top uut
  (
    .aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
    .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
    .s_rready, .mode_select_pin_bit, .secure_in, .cpu_req, .cpu_addr, .cpu_direct, .cpu_we(1'b0),
    .cpu_wdata(16'h0000), .cpu_gnt, .dbg_req, .dbg_addr, .dbg_we(1'b0), .dbg_wdata(16'h0000),
    .dbg_page_en, .dbg_page, .dbg_gnt, .dbg_denied, .mem_req, .mem_addr, .mem_we, .mem_wdata,
    .mem_from_dbg, .normal_single_chip, .background_debug, .sys_reset_req
  );
  mmc_master_model u_mst
  (
    .aclk, .cpu_gnt, .dbg_gnt, .dbg_denied, .mem_req, .mem_addr, .sys_reset_req, .cpu_req,
    .cpu_addr, .cpu_direct, .dbg_req, .dbg_addr, .dbg_page_en, .dbg_page
  );
  // ==========================================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // reset held three edges, long enough for the pin synchroniser
  task automatic do_reset(input logic pin, input logic sec);
    aresetn <= 1'b0;
    mode_select_pin_bit <= pin;
    secure_in <= sec;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask
  // address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d);
    logic aw_ok, w_ok;
    {aw_ok, w_ok} = 2'b00;
    s_awaddr <= a;
    s_wdata <= {24'h000000, d};
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      if (s_awvalid && s_awready)
      begin
        aw_ok = 1'b1;
        s_awvalid <= 1'b0;
      end
      if (s_wvalid && s_wready)
      begin
        w_ok = 1'b1;
        s_wvalid <= 1'b0;
      end
    end
    s_bready <= 1'b1;
    do @(posedge aclk); while (!s_bvalid);
    rsp_q = s_bresp;
    s_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_arready);
    s_arvalid <= 1'b0;
    s_rready <= 1'b1;
    do @(posedge aclk); while (!s_rvalid);
    {rd_q, rsp_q} = {s_rdata, s_rresp};
    s_rready <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    axi_rd(a);
    check(rd_q, exp);
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset_values();
    do_reset(1'b1, 1'b0);
    rd_chk(A_MODE, 32'h80);
    rd_chk(A_PAGE, 32'h0e);
    rd_chk(A_DIR, 32'h00);
    check(background_debug, 1'b0);
    axi_rd(8'h04);
    check(rsp_q, mmc_pkg::RESP_SLVERR);
    $display("reset values done");
  endtask
  task automatic t_mode();
    do_reset(1'b0, 1'b0);
    check(background_debug, 1'b1);
    check(normal_single_chip, 1'b0);
    axi_wr(A_MODE, 8'h80);
    rd_chk(A_MODE, 32'h80);
    check(normal_single_chip, 1'b1);
    axi_wr(A_MODE, 8'h00);
    rd_chk(A_MODE, 32'h80);
    rd_chk(A_STAT, 32'h01);
    check(background_debug, 1'b1);
    $display("mode writes done");
  endtask
  task automatic t_secure();
    do_reset(1'b0, 1'b1);
    axi_wr(A_MODE, 8'h80);
    rd_chk(A_MODE, 32'h00);
    u_mst.dbg_go(16'h8000, 1'b1, 4'hc);
    check(u_mst.seen_den, 1'b1);
    check(u_mst.seen_mem, 1'b0);
    secure_in <= 1'b0;
    u_mst.dbg_go(16'h8000, 1'b1, 4'hc);
    check(u_mst.seen_den, 1'b0);
    check(u_mst.seen_addr, 18'h30000);
    $display("security done");
  endtask
  task automatic t_paging();
    do_reset(1'b1, 1'b0);
    axi_wr(A_PAGE, 8'h0d);
    u_mst.cpu_go(16'h8123, 1'b0);
    check(u_mst.seen_addr, 18'h34123);
    u_mst.cpu_go(16'hc010, 1'b0);
    check(u_mst.seen_addr, 18'h3c010);
    u_mst.cpu_go(16'h1234, 1'b0);
    check(u_mst.seen_addr, 18'h31234);
    axi_wr(A_DIR, 8'h80);
    u_mst.cpu_go(16'h0045, 1'b1);
    check(u_mst.seen_addr, 18'h34045);
    u_mst.dbg_go(16'h8000, 1'b0, 4'h0);
    check(u_mst.seen_addr, 18'h34000);
    u_mst.dbg_go(16'h8000, 1'b1, 4'hf);
    check(u_mst.seen_addr, 18'h3c000);
    axi_wr(A_PAGE, 8'h02);
    u_mst.cpu_go(16'h8000, 1'b0);
    check(u_mst.seen_rst, 1'b1);
    check(u_mst.seen_mem, 1'b0);
    $display("paging done");
  endtask
  task automatic t_arb();
    fork
      u_mst.cpu_go(16'hc000, 1'b0);
      u_mst.dbg_go(16'hc000, 1'b0, 4'h0);
    join
    check(u_mst.cpu_t != u_mst.dbg_t, 1'b1);
    $display("arbitration done");
  endtask
  // clock, main sequence and watchdog
  initial
  begin
    forever #5 aclk = ~aclk;
  end
  initial
  begin
    t_reset_values();
    t_mode();
    t_secure();
    t_paging();
    t_arb();
    print_verdict();
  end
  initial
  begin
    #20us;
    num_errors++;
    print_verdict();
  end
endmodule
bind mmc_top mmc_checker u_chk
(
  .aclk, .aresetn, .secure_in, .cpu_addr, .cpu_direct, .cpu_gnt, .dbg_gnt, .dbg_denied, .mem_req,
  .mem_addr, .mem_from_dbg, .normal_single_chip, .background_debug, .sys_reset_req
);
`default_nettype wire
